// ---- csf_checker.sv ----
// Checker: concurrent properties on the csf_top ports.
// Assumes the bind below; reset is rst_i on clk_i.
`timescale 1ns/10ps
`default_nettype none
module csf_checker
    import csf_pkg::*;
(
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_ack_o,
    input wire logic              req_valid_i,
    input wire logic              req_ready_o,
    input wire logic              snp_valid_o,
    input wire logic              snp_ready_i,
    input wire logic [ADDR_W-1:0] snp_addr_o,
    input wire logic              mem_valid_o,
    input wire logic              mem_ready_i,
    input wire logic              mem_sel_o,
    input wire logic [ADDR_W-1:0] mem_addr_o,
    input wire logic              dvm_valid_o,
    input wire logic              dvm_ready_i,
    input wire logic [NSI-1:0]    dvm_mask_o,
    input wire logic              qaccept_no
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_in;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_in: assert property (p_ack_in) else $error("no ack");
    property p_ack_one;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("long ack");
    property p_snp_hold;
        snp_valid_o && !snp_ready_i |=> snp_valid_o && $stable(snp_addr_o);
    endproperty
    a_snp_hold: assert property (p_snp_hold) else $error("snoop dropped");
    property p_snp_line;
        snp_valid_o |-> snp_addr_o[5:0] == 6'h00;
    endproperty
    a_snp_line: assert property (p_snp_line) else $error("snoop unaligned");
    property p_mem_map;
        mem_valid_o |-> mem_sel_o == mem_addr_o[31];
    endproperty
    a_mem_map: assert property (p_mem_map) else $error("bad port select");
    property p_mem_hold;
        mem_valid_o && !mem_ready_i |=> mem_valid_o && $stable(mem_addr_o);
    endproperty
    a_mem_hold: assert property (p_mem_hold) else $error("memory dropped");
    property p_dvm_hold;
        dvm_valid_o && !dvm_ready_i |=> dvm_valid_o && $stable(dvm_mask_o);
    endproperty
    a_dvm_hold: assert property (p_dvm_hold) else $error("dvm dropped");
    property p_take;
        req_valid_i && req_ready_o |=> !req_ready_o [*2];
    endproperty
    a_take: assert property (p_take) else $error("ready after take");
    property p_quiet;
        !qaccept_no |-> !req_ready_o;
    endproperty
    a_quiet: assert property (p_quiet) else $error("ready when quiesced");
endmodule : csf_checker
bind csf_top csf_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .req_valid_i,
    .req_ready_o, .snp_valid_o, .snp_ready_i, .snp_addr_o, .mem_valid_o, .mem_ready_i, .mem_sel_o,
    .mem_addr_o, .dvm_valid_o, .dvm_ready_i, .dvm_mask_o, .qaccept_no);
`default_nettype wire

// ---- csf_far_end.sv ----
// Far side of one handshake: cluster snoop, memory or DVM acceptor.
// Assumes valid holds until ready; wait_i sets the stall length.
`timescale 1ns/10ps
`default_nettype none
module csf_far_end (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       valid_i,
    input  wire logic [3:0] wait_i,
    output logic            ready_o
);
    logic [3:0] cnt_q;
    always_ff @(posedge clk_i) begin
        if (rst_i || !valid_i || ready_o) begin
            cnt_q   <= 4'h0;
            ready_o <= 1'b0;
        end else if (cnt_q == wait_i) begin
            ready_o <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule : csf_far_end
`default_nettype wire

// ---- csf_pkg.sv ----
// Constants and types for the coherent snoop filter and snoop control unit.
// Assumes a single 10 MHz clock and a classic Wishbone register port.
package csf_pkg;

    // Interfaces and addressing
    localparam int NSI       = 4;
    localparam int SRC_W     = 2;
    localparam int ADDR_W    = 32;
    localparam int LINE_BITS = 6;
    localparam int MI_SEL_BIT = 31;

    // Directory geometry: tag store holds twice the configured size
    localparam int SF_LINES  = 64;
    localparam int NWAY      = 8;
    localparam int WAY_BITS  = 3;
    localparam int NSET      = (2 * SF_LINES) / NWAY;
    localparam int SET_BITS  = 4;
    localparam int TAG_W     = ADDR_W - LINE_BITS - SET_BITS;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_HWEN = 8'h08;

    // Control field positions and reset value
    localparam int         SNP_EN_LSB = 0;
    localparam int         DVM_EN_LSB = 4;
    localparam logic [7:0] CTRL_RST   = 8'h00;

    // Status field positions
    localparam int ST_PEND_BIT   = 0;
    localparam int ST_QUIES_BIT  = 1;
    localparam int ST_PSTATE_LSB = 2;

    // Architectural power states of the directory RAMs
    localparam logic [1:0] PS_ON  = 2'h0;
    localparam logic [1:0] PS_RET = 2'h1;
    localparam logic [1:0] PS_OFF = 2'h2;

    // Coherent request kinds
    typedef enum logic [2:0] {
        REQ_RD_SHARED,
        REQ_RD_UNIQUE,
        REQ_EVICT,
        REQ_WRITE,
        REQ_DVM
    } csf_req_t;

    // Control sequence
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOOKUP,
        ST_BINV,
        ST_SNOOP,
        ST_MEM,
        ST_DVM
    } csf_state_t;

endpackage : csf_pkg

// ---- csf_top.sv ----
// Snoop filter directory, snoop/DVM issue control, low-power handshakes.
// Assumes requests come from logic on clk_i; handshake and strap pins are
// asynchronous and are synchronised here.
`timescale 1ns/10ps
`default_nettype none

module csf_top
    import csf_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone register port
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [31:0]       wb_adr_i,
    input  wire logic [31:0]       wb_dat_i,
    input  wire logic [3:0]        wb_sel_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Reset-time straps
    input  wire logic [NSI-1:0]    snoop_channel_hw_enable_i,
    // Coherent request from the slave interfaces
    input  wire logic              req_valid_i,
    input  wire logic [2:0]        req_type_i,
    input  wire logic [SRC_W-1:0]  req_src_i,
    input  wire logic [ADDR_W-1:0] req_addr_i,
    output logic                   req_ready_o,
    // Snoop issue
    output logic                   snp_valid_o,
    output logic      [NSI-1:0]    snp_mask_o,
    output logic      [ADDR_W-1:0] snp_addr_o,
    output logic                   snp_clean_inv_o,
    input  wire logic              snp_ready_i,
    // Master port toward memory
    output logic                   mem_valid_o,
    output logic                   mem_sel_o,
    output logic      [ADDR_W-1:0] mem_addr_o,
    input  wire logic              mem_ready_i,
    // DVM broadcast
    output logic                   dvm_valid_o,
    output logic      [NSI-1:0]    dvm_mask_o,
    input  wire logic              dvm_ready_i,
    // Completion
    output logic                   done_o,
    output logic                   hit_o,
    // Clock quiescence handshake
    input  wire logic              qreq_ni,
    output logic                   qaccept_no,
    output logic                   qactive_o,
    // Power state handshake
    input  wire logic              preq_i,
    input  wire logic [1:0]        pstate_i,
    output logic                   paccept_o,
    output logic                   ram_retain_o
);

    function automatic logic [NSI-1:0] csf_onehot(input logic [SRC_W-1:0] s);
        csf_onehot    = '0;
        csf_onehot[s] = 1'b1;
    endfunction : csf_onehot

    // Synchronisers
    logic             rst_s1_q;
    logic             rst;
    logic             qreq_n_s1_q;
    logic             qreq_n_s2_q;
    logic             preq_s1_q;
    logic             preq_s2_q;
    logic [1:0]       pst_s1_q;
    logic [1:0]       pst_s2_q;
    logic [NSI-1:0]   hwen_s1_q;
    logic [NSI-1:0]   hwen_s2_q;

    // Control state
    csf_state_t       state_q;
    csf_req_t         type_q;
    logic [SRC_W-1:0] src_q;
    logic [ADDR_W-1:0] addr_q;
    logic             rdy_q;
    logic [WAY_BITS-1:0] vic_q;
    logic [7:0]       ctrl_q;
    logic [NSI-1:0]   eff_snp_q;
    logic [NSI-1:0]   eff_dvm_q;
    logic             pend_q;
    logic [NSI-1:0]   hw_en_q;
    logic             qacc_n_q;
    logic             qact_q;
    logic             pacc_q;
    logic [1:0]       pwr_q;
    logic             ret_q;
    logic             dir_clr;

    // Directory storage
    logic             dir_vld_q [NSET][NWAY];
    logic [TAG_W-1:0] dir_tag_q [NSET][NWAY];
    logic [NSI-1:0]   dir_own_q [NSET][NWAY];

    // Bus
    logic             ack_q;
    logic [31:0]      dat_q;
    logic             wr_ctrl;
    logic [31:0]      rdata;

    // Reset and pin synchronisers, no reset so the chain runs during reset
    always_ff @(posedge clk_i) begin
        rst_s1_q    <= rst_i;
        rst         <= rst_s1_q;
        qreq_n_s1_q <= qreq_ni;
        qreq_n_s2_q <= qreq_n_s1_q;
        preq_s1_q   <= preq_i;
        preq_s2_q   <= preq_s1_q;
        pst_s1_q    <= pstate_i;
        pst_s2_q    <= pst_s1_q;
        hwen_s1_q   <= snoop_channel_hw_enable_i;
        hwen_s2_q   <= hwen_s1_q;
    end

    // Straps frozen at reset release
    always_ff @(posedge clk_i) begin
        if (rst) begin
            hw_en_q <= hwen_s2_q;
        end
    end

    logic [NSI-1:0]   snp_allow;
    logic [NSI-1:0]   dvm_allow;
    logic             idle;
    logic             take;
    logic [SET_BITS-1:0] cur_set;
    logic [TAG_W-1:0] cur_tag;

    assign snp_allow = eff_snp_q & hw_en_q;
    assign dvm_allow = eff_dvm_q & hw_en_q;
    assign idle      = (state_q == ST_IDLE);
    assign take      = req_valid_i & rdy_q;
    assign cur_set   = addr_q[LINE_BITS +: SET_BITS];
    assign cur_tag   = addr_q[ADDR_W-1 -: TAG_W];

    // Lookup over the eight ways of the selected set
    logic                hit;
    logic [WAY_BITS-1:0] hit_way;
    logic                free;
    logic [WAY_BITS-1:0] free_way;

    always_comb begin
        hit      = 1'b0;
        hit_way  = '0;
        free     = 1'b0;
        free_way = '0;
        for (int w = NWAY - 1; w >= 0; w--) begin
            if (dir_vld_q[cur_set][w] && dir_tag_q[cur_set][w] == cur_tag) begin
                hit     = 1'b1;
                hit_way = WAY_BITS'(w);
            end
            if (!dir_vld_q[cur_set][w]) begin
                free     = 1'b1;
                free_way = WAY_BITS'(w);
            end
        end
    end

    // Directory decision for the request under lookup
    logic [NSI-1:0]      src1;
    logic [NSI-1:0]      hit_own;
    logic [NSI-1:0]      others;
    logic                dir_we;
    logic                dir_upd;
    logic [WAY_BITS-1:0] wr_way;
    logic                wr_vld;
    logic [NSI-1:0]      wr_own;
    logic [NSI-1:0]      snp_m;
    logic [NSI-1:0]      binv_m;
    logic                to_mem;
    logic                use_vic;

    always_comb begin
        src1    = csf_onehot(src_q);
        hit_own = dir_own_q[cur_set][hit_way];
        others  = hit_own & ~src1;
        dir_we  = 1'b0;
        wr_way  = hit_way;
        wr_vld  = 1'b1;
        wr_own  = hit_own;
        snp_m   = '0;
        binv_m  = '0;
        to_mem  = 1'b0;
        use_vic = 1'b0;
        case (type_q)
            REQ_EVICT: begin
                if (hit) begin
                    dir_we = 1'b1;
                    wr_own = hit_own & ~src1;
                    wr_vld = |(hit_own & ~src1);
                end
            end
            REQ_WRITE: begin
                to_mem = 1'b1;
            end
            REQ_RD_SHARED, REQ_RD_UNIQUE: begin
                dir_we = 1'b1;
                if (hit) begin
                    snp_m  = others & snp_allow;
                    to_mem = (snp_m == '0);
                    // Unique read drops every other holder, snooped or not
                    wr_own = (type_q == REQ_RD_UNIQUE) ? src1 : (hit_own | src1);
                end else begin
                    wr_own = src1;
                    to_mem = 1'b1;
                    if (free) begin
                        wr_way = free_way;
                    end else begin
                        wr_way  = vic_q;
                        use_vic = 1'b1;
                        binv_m  = dir_own_q[cur_set][vic_q] & snp_allow;
                    end
                end
            end
            default: begin
            end
        endcase
        // Storage only sees enables in the lookup cycle
        dir_upd = dir_we && (state_q == ST_LOOKUP);
    end

    // Directory valid bits; a power-off entry loses the contents
    always_ff @(posedge clk_i) begin
        if (rst || dir_clr) begin
            for (int s = 0; s < NSET; s++) begin
                for (int w = 0; w < NWAY; w++) begin
                    dir_vld_q[s][w] <= 1'b0;
                end
            end
        end else if (dir_upd) begin
            dir_vld_q[cur_set][wr_way] <= wr_vld;
        end
    end

    // Tags and holder masks, qualified by the valid bits
    always_ff @(posedge clk_i) begin
        if (dir_upd) begin
            dir_tag_q[cur_set][wr_way] <= cur_tag;
            dir_own_q[cur_set][wr_way] <= wr_own;
        end
    end

    // Request sequencing and issue outputs
    always_ff @(posedge clk_i) begin
        if (rst) begin
            state_q         <= ST_IDLE;
            type_q          <= REQ_RD_SHARED;
            src_q           <= '0;
            addr_q          <= '0;
            vic_q           <= '0;
            snp_valid_o     <= 1'b0;
            snp_mask_o      <= '0;
            snp_addr_o      <= '0;
            snp_clean_inv_o <= 1'b0;
            mem_valid_o     <= 1'b0;
            dvm_valid_o     <= 1'b0;
            dvm_mask_o      <= '0;
            done_o          <= 1'b0;
            hit_o           <= 1'b0;
        end else begin
            done_o <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (take) begin
                        type_q <= csf_req_t'(req_type_i);
                        src_q  <= req_src_i;
                        addr_q <= req_addr_i;
                        hit_o  <= 1'b0;
                        if (csf_req_t'(req_type_i) == REQ_DVM) begin
                            // Directory is bypassed entirely
                            if ((dvm_allow & ~csf_onehot(req_src_i)) != '0) begin
                                dvm_valid_o <= 1'b1;
                                dvm_mask_o  <= dvm_allow & ~csf_onehot(req_src_i);
                                state_q     <= ST_DVM;
                            end else begin
                                done_o <= 1'b1;
                            end
                        end else begin
                            state_q <= ST_LOOKUP;
                        end
                    end
                end
                ST_LOOKUP: begin
                    hit_o <= hit;
                    if (use_vic) begin
                        vic_q <= vic_q + 1'b1;
                    end
                    if (binv_m != '0) begin
                        snp_valid_o     <= 1'b1;
                        snp_mask_o      <= binv_m;
                        snp_addr_o      <= {dir_tag_q[cur_set][vic_q], cur_set, {LINE_BITS{1'b0}}};
                        snp_clean_inv_o <= 1'b1;
                        state_q         <= ST_BINV;
                    end else if (snp_m != '0) begin
                        snp_valid_o     <= 1'b1;
                        snp_mask_o      <= snp_m;
                        snp_addr_o      <= {addr_q[ADDR_W-1:LINE_BITS], {LINE_BITS{1'b0}}};
                        snp_clean_inv_o <= (type_q == REQ_RD_UNIQUE);
                        state_q         <= ST_SNOOP;
                    end else if (to_mem) begin
                        mem_valid_o <= 1'b1;
                        state_q     <= ST_MEM;
                    end else begin
                        done_o  <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
                ST_BINV: begin
                    if (snp_ready_i) begin
                        snp_valid_o <= 1'b0;
                        mem_valid_o <= 1'b1;
                        state_q     <= ST_MEM;
                    end
                end
                ST_SNOOP: begin
                    if (snp_ready_i) begin
                        snp_valid_o <= 1'b0;
                        done_o      <= 1'b1;
                        state_q     <= ST_IDLE;
                    end
                end
                ST_MEM: begin
                    if (mem_ready_i) begin
                        mem_valid_o <= 1'b0;
                        done_o      <= 1'b1;
                        state_q     <= ST_IDLE;
                    end
                end
                ST_DVM: begin
                    if (dvm_ready_i) begin
                        dvm_valid_o <= 1'b0;
                        done_o      <= 1'b1;
                        state_q     <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    assign mem_addr_o = addr_q;
    assign mem_sel_o  = addr_q[MI_SEL_BIT];
    assign req_ready_o = rdy_q;

    // Request acceptance; quiesced or non-ON power state stalls the port
    always_ff @(posedge clk_i) begin
        if (rst) begin
            rdy_q <= 1'b0;
        end else begin
            rdy_q <= idle && !take && qacc_n_q && qreq_n_s2_q
                  && (pwr_q == PS_ON) && !(preq_s2_q && !pacc_q);
        end
    end

    // Clock quiescence handshake, accepted only between requests
    always_ff @(posedge clk_i) begin
        if (rst) begin
            qacc_n_q <= 1'b1;
            qact_q   <= 1'b0;
        end else begin
            qact_q <= !idle || req_valid_i;
            if (qreq_n_s2_q) begin
                qacc_n_q <= 1'b1;
            end else if (idle && !take) begin
                qacc_n_q <= 1'b0;
            end
        end
    end

    assign qaccept_no = qacc_n_q;
    assign qactive_o  = qact_q;

    // Power state handshake for the directory RAMs
    always_ff @(posedge clk_i) begin
        if (rst) begin
            pacc_q  <= 1'b0;
            pwr_q   <= PS_ON;
            ret_q   <= 1'b0;
            dir_clr <= 1'b0;
        end else begin
            dir_clr <= 1'b0;
            if (!preq_s2_q) begin
                pacc_q <= 1'b0;
            end else if (!pacc_q && idle && !take) begin
                pacc_q  <= 1'b1;
                pwr_q   <= pst_s2_q;
                ret_q   <= (pst_s2_q == PS_RET);
                dir_clr <= (pst_s2_q == PS_OFF);
            end
        end
    end

    assign paccept_o    = pacc_q;
    assign ram_retain_o = ret_q;

    // Enables take effect only between requests
    always_ff @(posedge clk_i) begin
        if (rst) begin
            eff_snp_q <= '0;
            eff_dvm_q <= '0;
        end else if (idle && !take) begin
            eff_snp_q <= ctrl_q[SNP_EN_LSB +: NSI];
            eff_dvm_q <= ctrl_q[DVM_EN_LSB +: NSI];
        end
    end

    // Wishbone slave: one wait state, write lands on the acked edge
    assign wr_ctrl = ack_q && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
                  && (wb_adr_i == {24'h000000, REG_CTRL});

    always_comb begin
        rdata = 32'h00000000;
        if (wb_adr_i[31:8] == 24'h000000) begin
            case (wb_adr_i[7:0])
                REG_CTRL: rdata[7:0] = ctrl_q;
                REG_STAT: begin
                    rdata[ST_PEND_BIT]          = pend_q;
                    rdata[ST_QUIES_BIT]         = !qacc_n_q;
                    rdata[ST_PSTATE_LSB +: 2]   = pwr_q;
                end
                REG_HWEN: rdata[NSI-1:0] = hw_en_q;
                default: rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst) begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
            dat_q <= rdata;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // Control register and pending flag; a new write outranks the clear
    always_ff @(posedge clk_i) begin
        if (rst) begin
            ctrl_q <= CTRL_RST;
            pend_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= wb_dat_i[7:0];
                pend_q <= 1'b1;
            end else if ({eff_dvm_q, eff_snp_q} == ctrl_q) begin
                pend_q <= 1'b0;
            end
        end
    end

endmodule : csf_top

`default_nettype wire

// ---- testbench.sv ----
// Testbench for csf_top: register port, request port, low-power pins.
// Assumes three csf_far_end partners answer snoop, memory and DVM.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import csf_pkg::*;
    logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic        req_valid_i = 1'b0, qreq_ni = 1'b1, preq_i = 1'b0, s_ci, m_sel;
    logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, req_addr_i = 32'h0, wb_dat_o, snp_addr_o, mem_addr_o, rd, s_adr;
    logic [3:0]  wb_sel_i = 4'hf, snoop_channel_hw_enable_i = 4'h7, w_snp = 4'h0, w_mem = 4'h0, w_dvm = 4'h0;
    logic [3:0]  snp_mask_o, dvm_mask_o, s_msk, d_msk;
    logic [31:0] m_adr;
    logic [2:0]  req_type_i = 3'h0;
    logic [1:0]  req_src_i = 2'h0, pstate_i = 2'h0;
    logic        wb_ack_o, req_ready_o, snp_valid_o, snp_clean_inv_o, snp_ready_i, mem_valid_o, mem_sel_o;
    logic        mem_ready_i, dvm_valid_o, dvm_ready_i, done_o, hit_o, qaccept_no, qactive_o, paccept_o, ram_retain_o;
    int          num_errors = 0, n_compared = 0, n_snp, n_mem, n_dvm;
    csf_top dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o,
        .wb_ack_o, .snoop_channel_hw_enable_i, .req_valid_i, .req_type_i, .req_src_i, .req_addr_i, .req_ready_o,
        .snp_valid_o, .snp_mask_o, .snp_addr_o, .snp_clean_inv_o, .snp_ready_i, .mem_valid_o, .mem_sel_o,
        .mem_addr_o, .mem_ready_i, .dvm_valid_o, .dvm_mask_o, .dvm_ready_i, .done_o, .hit_o, .qreq_ni,
        .qaccept_no, .qactive_o, .preq_i, .pstate_i, .paccept_o, .ram_retain_o);
    csf_far_end u_snp (.clk_i, .rst_i, .valid_i(snp_valid_o), .wait_i(w_snp), .ready_o(snp_ready_i));
    csf_far_end u_mem (.clk_i, .rst_i, .valid_i(mem_valid_o), .wait_i(w_mem), .ready_o(mem_ready_i));
    csf_far_end u_dvm (.clk_i, .rst_i, .valid_i(dvm_valid_o), .wait_i(w_dvm), .ready_o(dvm_ready_i));
    initial forever #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (snp_valid_o && snp_ready_i) begin
            n_snp++;
            s_msk = snp_mask_o;
            s_adr = snp_addr_o;
            s_ci = snp_clean_inv_o;
        end
        if (mem_valid_o && mem_ready_i) begin
            n_mem++;
            m_sel = mem_sel_o;
            m_adr = mem_addr_o;
        end
        if (dvm_valid_o && dvm_ready_i) begin
            n_dvm++;
            d_msk = dvm_mask_o;
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
        wb_adr_i <= {24'h0, a};
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask : wb
    task automatic rq(input logic [2:0] t, input logic [1:0] s, input logic [31:0] a);
        {n_snp, n_mem, n_dvm} = '0;
        @(posedge clk_i);
        req_valid_i <= 1'b1;
        {req_type_i, req_src_i, req_addr_i} <= {t, s, a};
        do @(posedge clk_i); while (req_ready_o !== 1'b1);
        req_valid_i <= 1'b0;
        do @(posedge clk_i); while (done_o !== 1'b1);
        repeat (2) @(posedge clk_i);
    endtask : rq
    task automatic t_regs;
        wb(0, REG_CTRL, 0, rd); chk("ctrl reset", rd, 32'h0);
        wb(0, REG_HWEN, 0, rd); chk("hwen", rd, 32'h7);
        snoop_channel_hw_enable_i <= 4'hf;
        wb(0, REG_HWEN, 0, rd); chk("hwen late", rd, 32'h7);
        wb(0, 8'h0c, 0, rd); chk("unmapped", rd, 32'h0);
        wb(1, REG_CTRL, 32'hff, rd);
        wb(0, REG_STAT, 0, rd); chk("pend set", rd[ST_PEND_BIT], 1);
        for (int i = 0; i < 8 && rd[ST_PEND_BIT] !== 1'b0; i++) wb(0, REG_STAT, 0, rd);
        chk("pending", rd[ST_PEND_BIT], 0);
        chk("pstate", rd[ST_PSTATE_LSB+:2], PS_ON);
        $display("end t_regs");
    endtask : t_regs
    task automatic t_coh;
        rq(REQ_RD_SHARED, 0, 32'h8000_0040); chk("miss hit", hit_o, 0);
        chk("miss mem", n_mem, 1); chk("miss sel", m_sel, 1); chk("miss snp", n_snp, 0);
        chk("miss addr", m_adr, 32'h8000_0040);
        rq(REQ_RD_UNIQUE, 1, 32'h8000_0040); chk("alloc hit", hit_o, 1);
        chk("uniq snp", n_snp, 1); chk("uniq mask", s_msk, 4'h1); chk("uniq ci", s_ci, 1);
        chk("uniq adr", s_adr, 32'h8000_0040);
        rq(REQ_EVICT, 1, 32'h8000_0040);
        rq(REQ_RD_SHARED, 2, 32'h8000_0040); chk("evict hit", hit_o, 0);
        wb(1, REG_CTRL, 32'hfb, rd);
        rq(REQ_RD_UNIQUE, 0, 32'h8000_0040); chk("off hit", hit_o, 1); chk("off snp", n_snp, 0);
        wb(1, REG_CTRL, 32'hff, rd);
        rq(REQ_RD_SHARED, 3, 32'h0000_0080);
        rq(REQ_RD_UNIQUE, 0, 32'h0000_0080); chk("hw hit", hit_o, 1); chk("hw snp", n_snp, 0);
        rq(REQ_WRITE, 1, 32'h0000_1000); chk("wr mem", n_mem, 1); chk("wr sel", m_sel, 0);
        $display("end t_coh");
    endtask : t_coh
    task automatic t_dvm;
        w_dvm <= 4'h2;
        rq(REQ_DVM, 0, 32'h0); chk("dvm n", n_dvm, 1); chk("dvm mask", d_msk, 4'h6);
        chk("dvm hit", hit_o, 0);
        $display("end t_dvm");
    endtask : t_dvm
    task automatic t_full;
        w_snp <= 4'h3;
        w_mem <= 4'h2;
        for (int i = 0; i < 9; i++) begin
            rq(REQ_RD_SHARED, 0, 32'h140 | (i << 10)); chk("fill snp", n_snp, i == 8);
        end
        chk("binv ci", s_ci, 1); chk("binv mask", s_msk, 4'h1); chk("binv mem", n_mem, 1);
        chk("binv set", s_adr[9:0], 10'h140);
        $display("end t_full");
    endtask : t_full
    task automatic t_low;
        qreq_ni <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk("qaccept", qaccept_no, 0); chk("q ready", req_ready_o, 0);
        chk("qactive", qactive_o, 0);
        qreq_ni <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk("qrelease", qaccept_no, 1);
        {preq_i, pstate_i} <= {1'b1, PS_RET};
        repeat (8) @(posedge clk_i);
        chk("paccept", paccept_o, 1); chk("retain", ram_retain_o, 1);
        preq_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk("pdrop", paccept_o, 0);
        {preq_i, pstate_i} <= {1'b1, PS_OFF};
        repeat (8) @(posedge clk_i);
        preq_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        {preq_i, pstate_i} <= {1'b1, PS_ON};
        repeat (8) @(posedge clk_i);
        chk("on retain", ram_retain_o, 0);
        preq_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        rq(REQ_RD_UNIQUE, 0, 32'h0000_0080); chk("off cleared", hit_o, 0);
        $display("end t_low");
    endtask : t_low
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        t_regs();
        t_coh();
        t_dvm();
        t_full();
        t_low();
        end_of_test();
    end
    initial begin
        #2000000;
        num_errors++;
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
